// File: hdl/psf_pkg.sv
// Constants, types and register layout of the synthesizer status block.
// Assumes a single 20 MHz clock and a plain strobe register port.
//
// What this block does
// - Only the two loss flags react to status writes; other bits ignore writes.
// - Lock-loss flag at bit 9 requests service; write 1 clears, 0 keeps.
// - Lock loss from reset, multiplier change or modulation enable never sets flag.
// - Lock-loss flag stays set until reset or a write of 1.
// - Bit 8 shows live clock loss in the PLL modes.
// - Live clock-loss bit drops by itself when clocks recover.
// - Clock-loss detection works only while its enable bit is 1.
// - Live clock-loss bit always reads 0 in external clock mode.
// - A read meeting a fresh clock loss may return the old value.
// - Bit 7 is read-only clock mode caught at reset: 1 means PLL.
// - Bit 6 is PLL sub-mode: 1 normal, 0 for 1:1 and external.
// - Bit 5 is reference source in normal mode: 1 crystal, 0 external.
// - Sticky lock bit 4 sets on lock after reset, multiplier change or modulation.
// - Sticky lock clears on lock loss and stays clear after plain relock.
// - After reset sticky lock reads 0 in external mode, and 1 in PLL modes once the first lock is seen.
// - A read meeting a lock loss may return the old sticky value.
// - Live lock bit 3 is 1 while the PLL reports lock.
// - A read meeting a lock change may return the stale live lock value.
// - Power-on reset release waits for live lock in the PLL modes only.
// - Live lock reads 0 in external clock mode.
// - Clock-loss flag at bit 2: write 1 clears, 0 keeps, reset clears.
// - Clock-loss flag stays set after recovery until write 1 or reset.
// - Mode bits encode 000 bypass, 100 one-to-one, 110 normal ext, 111 crystal.
// - Set clock-loss flag with both interrupt and detection enables requests an interrupt at once.
package psf_pkg;

    localparam int          ADDR_W           = 8;
    localparam int          DATA_W           = 32;
    localparam logic [7:0]  STATUS_ADDR      = 8'h00;
    localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;
    localparam int          LOL_FLAG_BIT     = 9;
    localparam int          CLK_LOSS_BIT     = 8;
    localparam int          PLL_USED_BIT     = 7;
    localparam int          NORMAL_SEL_BIT   = 6;
    localparam int          CRYSTAL_REF_BIT  = 5;
    localparam int          LOCK_STICKY_BIT  = 4;
    localparam int          LOCK_LIVE_BIT    = 3;
    localparam int          LOC_FLAG_BIT     = 2;
    localparam int          MODE_PLL_IDX     = 2;
    localparam int          MODE_NORMAL_IDX  = 1;
    localparam int          MODE_CRYSTAL_IDX = 0;

    typedef enum logic [1:0]
    {
        PSF_WAIT_SYNC1 = 2'h0,
        PSF_WAIT_SYNC2 = 2'h1,
        PSF_CAPTURE    = 2'h3,
        PSF_RUN        = 2'h2
    } psf_phase_e;

    typedef struct packed
    {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } psf_bus_req_s;

    typedef struct packed
    {
        logic       detect_en;
        logic       irq_en;
        logic       mult_change;
        logic       fm_enable;
    } psf_ctrl_s;

    typedef struct packed
    {
        psf_phase_e  phase;
        logic [4:0]  sync1;
        logic [4:0]  sync2;
        logic [2:0]  mode;
        logic        armed;
        logic        sticky;
        logic        lock_prev;
        logic        lock_loss_flag;
        logic        clock_loss_flag;
        logic [31:0] rdata;
    } psf_state_s;

endpackage

// File: hdl/psf_status.sv
// Synthesizer status register with lock and clock-loss flags.
// Assumes lock, clock-loss and strap inputs are asynchronous pins; control
// strobes come from the synthesizer control register on the same clock.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module psf_status
(
    input  wire logic                 clk_in,
    input  wire logic                 arst_n_in,
    input  wire psf_pkg::psf_bus_req_s bus_in,
    output logic [31:0]               rd_data_out,
    input  wire psf_pkg::psf_ctrl_s   ctrl_in,
    input  wire logic                 pll_lock_in,
    input  wire logic                 clock_fail_in,
    input  wire logic [2:0]           clk_mode_strap_in,
    output logic                      lock_live_out,
    output logic                      por_release_ok_out,
    output logic                      lock_loss_irq_out,
    output logic                      clock_loss_irq_out
);
    import psf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic [2:0] mode_decode(input logic [2:0] strap);
        mode_decode = {strap[2], strap[2] & strap[1], strap[2] & strap[1] & strap[0]};
    endfunction

    function automatic logic hit(input psf_bus_req_s req);
        hit = (req.addr == STATUS_ADDR);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State and combinational terms

    psf_state_s st;
    psf_state_s next_st;

    logic        pll_used;
    logic        lock_s;
    logic        lock_live;
    logic        lock_fall;
    logic        lock_rise;
    logic        clock_loss_live;
    logic        wr_hit;
    logic        clr_lol;
    logic        clr_loc;
    logic        lol_event;
    logic [31:0] status_word;

    assign pll_used        = st.mode[MODE_PLL_IDX];
    assign lock_s          = st.sync2[4];
    assign lock_live       = lock_s & pll_used & (st.phase == PSF_RUN);
    assign lock_fall       = st.lock_prev & ~lock_live;
    assign lock_rise       = ~st.lock_prev & lock_live;
    assign clock_loss_live = st.sync2[3] & ctrl_in.detect_en & pll_used;
    assign wr_hit          = bus_in.wr & hit(bus_in);
    assign clr_lol         = wr_hit & bus_in.wdata[LOL_FLAG_BIT];
    assign clr_loc         = wr_hit & bus_in.wdata[LOC_FLAG_BIT];
    assign lol_event       = lock_fall & pll_used & ~st.armed;

    always_comb
    begin
        status_word                  = STATUS_RESET;
        status_word[LOL_FLAG_BIT]    = st.lock_loss_flag;
        status_word[CLK_LOSS_BIT]    = clock_loss_live;
        status_word[PLL_USED_BIT]    = st.mode[MODE_PLL_IDX];
        status_word[NORMAL_SEL_BIT]  = st.mode[MODE_NORMAL_IDX];
        status_word[CRYSTAL_REF_BIT] = st.mode[MODE_CRYSTAL_IDX];
        status_word[LOCK_STICKY_BIT] = st.sticky;
        status_word[LOCK_LIVE_BIT]   = lock_live;
        status_word[LOC_FLAG_BIT]    = st.clock_loss_flag;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        next_st       = st;
        next_st.sync1 = {pll_lock_in, clock_fail_in, clk_mode_strap_in};
        next_st.sync2 = st.sync1;
        next_st.rdata = 32'h0;
        case (st.phase)
            PSF_WAIT_SYNC1:
            begin
                next_st.phase = PSF_WAIT_SYNC2;
            end
            PSF_WAIT_SYNC2:
            begin
                next_st.phase = PSF_CAPTURE;
            end
            PSF_CAPTURE:
            begin
                next_st.phase = PSF_RUN;
                next_st.mode  = mode_decode(st.sync2[2:0]);
                next_st.armed = st.sync2[2];
            end
            PSF_RUN:
            begin
                next_st.lock_prev = lock_live;
                if (ctrl_in.mult_change | ctrl_in.fm_enable)
                begin
                    next_st.armed = pll_used;
                end
                else if (st.armed & lock_rise)
                begin
                    next_st.armed = 1'b0;
                end
                if (lock_fall)
                begin
                    next_st.sticky = 1'b0;
                end
                else if (st.armed & lock_rise)
                begin
                    next_st.sticky = 1'b1;
                end
                if (lol_event)
                begin
                    next_st.lock_loss_flag = 1'b1;
                end
                else if (clr_lol)
                begin
                    next_st.lock_loss_flag = 1'b0;
                end
                if (clock_loss_live)
                begin
                    next_st.clock_loss_flag = 1'b1;
                end
                else if (clr_loc)
                begin
                    next_st.clock_loss_flag = 1'b0;
                end
            end
            default:
            begin
                next_st.phase = PSF_WAIT_SYNC1;
            end
        endcase
        if (bus_in.rd & hit(bus_in))
        begin
            next_st.rdata = status_word;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rd_data_out        = st.rdata;
    assign lock_live_out      = lock_live;
    assign por_release_ok_out = (st.phase == PSF_RUN) & (~pll_used | lock_s);
    assign lock_loss_irq_out  = st.lock_loss_flag;
    assign clock_loss_irq_out = st.clock_loss_flag & ctrl_in.irq_en & ctrl_in.detect_en;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    chk_reserved_zero: assert property (rd_data_out[31:10] == 22'h0)
        else $error("reserved status bits not zero");

    chk_lock_loss_flag_clear: assert property (clr_lol && !lol_event |=> !st.lock_loss_flag)
        else $error("lock-loss flag not cleared by write of one");

    chk_lock_loss_flag_exempt: assert property (st.armed && lock_fall && !clr_lol |=> st.lock_loss_flag == $past(st.lock_loss_flag))
        else $error("lock-loss flag set on exempt lock loss");

    chk_lock_loss_flag_hold: assert property (st.lock_loss_flag && !clr_lol |=> st.lock_loss_flag)
        else $error("lock-loss flag dropped without clear");

    chk_loc_read: assert property (bus_in.rd && hit(bus_in) |=> rd_data_out[8] == $past(clock_loss_live))
        else $error("read of live clock loss wrong");

    chk_loc_gate: assert property (!ctrl_in.detect_en || !pll_used |-> !status_word[8])
        else $error("clock loss shown while detection off");

    chk_mode_stable: assert property (st.phase == PSF_RUN |=> $stable(st.mode))
        else $error("mode bits changed after reset");

    chk_submode_ext: assert property (!st.mode[2] |-> st.mode[1:0] == 2'h0)
        else $error("sub-mode set in external mode");

    chk_sticky_clear: assert property (lock_fall |=> !st.sticky)
        else $error("sticky lock kept after lock loss");

    chk_sticky_set: assert property (st.armed && lock_rise |=> st.sticky)
        else $error("sticky lock not set on qualified relock");

    chk_lock_ext: assert property (!pll_used |-> !lock_live_out)
        else $error("live lock set in external mode");

    chk_clock_loss_flag_hold: assert property (st.clock_loss_flag && !clr_loc |=> st.clock_loss_flag)
        else $error("clock-loss flag dropped without clear");

    chk_irq_now: assert property (st.clock_loss_flag && ctrl_in.irq_en && ctrl_in.detect_en |-> clock_loss_irq_out)
        else $error("clock-loss interrupt not requested");

    cov_lol_set: cover property (!st.lock_loss_flag ##1 st.lock_loss_flag);
    cov_loc_set: cover property (!st.clock_loss_flag ##1 st.clock_loss_flag);
    cov_relock: cover property (st.armed ##1 st.sticky);
    cov_clear: cover property (st.lock_loss_flag && clr_lol ##1 !st.lock_loss_flag);

endmodule // psf_status

// File: test/pll_synth_status_flags_test.sv
// Self-checking bench for the synthesizer status register block.
// Assumes the psf_pkg package and the psf_status module are compiled first.
`timescale 1ns/10ps
module pll_synth_status_flags_test;
    import psf_pkg::*;
    logic         clk_in;
    logic         arst_n_in;
    psf_bus_req_s bus;
    psf_ctrl_s    ctrl;
    logic         pll_lock_in;
    logic         clock_fail_in;
    logic [2:0]   strap;
    logic [31:0]  rd_data_out;
    logic         lock_live_out;
    logic         por_ok;
    logic         lol_irq;
    logic         loc_irq;
    int           err_count;
    int           total_checks;
    logic [31:0]  got;
    ////////////////////////////////////////////////////////////////////////////
    psf_status dut
    (
        .clk_in             (clk_in),
        .arst_n_in          (arst_n_in),
        .bus_in             (bus),
        .rd_data_out        (rd_data_out),
        .ctrl_in            (ctrl),
        .pll_lock_in        (pll_lock_in),
        .clock_fail_in      (clock_fail_in),
        .clk_mode_strap_in  (strap),
        .lock_live_out      (lock_live_out),
        .por_release_ok_out (por_ok),
        .lock_loss_irq_out  (lol_irq),
        .clock_loss_irq_out (loc_irq)
    );
    always #25 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] exp, input logic [31:0] act);
        total_checks++;
        if (act !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus <= '{addr: 8'h00, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus <= '{addr: 8'h00, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
        #1 d = rd_data_out;
    endtask
    task automatic do_reset(input logic [2:0] s);
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        strap     <= s;
        wait_cyc(12);
        @(posedge clk_in);
        arst_n_in <= 1'b1;
        wait_cyc(5);
    endtask
    task automatic pulse_ctrl(input int which);
        @(posedge clk_in);
        if (which == 0) ctrl.mult_change <= 1'b1; else ctrl.fm_enable <= 1'b1;
        @(posedge clk_in);
        ctrl.mult_change <= 1'b0;
        ctrl.fm_enable   <= 1'b0;
    endtask
    task automatic set_lock(input logic v);
        @(posedge clk_in);
        pll_lock_in <= v;
        wait_cyc(6);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_modes();
        logic [2:0]  codes [3] = '{3'b111, 3'b110, 3'b100};
        logic [31:0] exps  [3] = '{32'h0f8, 32'h0d8, 32'h098};
        pll_lock_in = 1'b0;
        do_reset(3'b111);
        chk(32'h0, {31'h0, por_ok});
        set_lock(1'b1);
        chk(32'h1, {31'h0, por_ok});
        for (int i = 0; i < 3; i++)
        begin
            do_reset(codes[i]);
            rd(8'h00, got);
            chk(exps[i], got);
        end
    endtask
    task automatic test_lock_loss();
        set_lock(1'b0);
        chk(32'h1, {31'h0, lol_irq});
        rd(8'h00, got);
        chk(32'h2e0, got);
        set_lock(1'b1);
        rd(8'h00, got);
        chk(32'h2e8, got);
        wr(8'h00, 32'hffff_fdff);
        rd(8'h00, got);
        chk(32'h2e8, got);
        wr(8'h00, 32'h0000_0200);
        rd(8'h00, got);
        chk(32'h0e8, got);
        chk(32'h0, {31'h0, lol_irq});
    endtask
    task automatic test_exempt();
        for (int i = 0; i < 2; i++)
        begin
            pulse_ctrl(i);
            set_lock(1'b0);
            rd(8'h00, got);
            chk(32'h0e0, got);
            set_lock(1'b1);
            rd(8'h00, got);
            chk(32'h0f8, got);
        end
    endtask
    task automatic test_clock_loss();
        @(posedge clk_in);
        ctrl.irq_en <= 1'b1;
        clock_fail_in <= 1'b1;
        wait_cyc(6);
        rd(8'h00, got);
        chk(32'h0f8, got);
        chk(32'h0, {31'h0, loc_irq});
        @(posedge clk_in);
        ctrl.detect_en <= 1'b1;
        wait_cyc(6);
        rd(8'h00, got);
        chk(32'h1fc, got);
        chk(32'h1, {31'h0, loc_irq});
        @(posedge clk_in);
        clock_fail_in <= 1'b0;
        wait_cyc(6);
        rd(8'h00, got);
        chk(32'h0fc, got);
        wr(8'h00, 32'h0000_0004);
        rd(8'h00, got);
        chk(32'h0f8, got);
    endtask
    task automatic test_external();
        do_reset(3'b000);
        clock_fail_in <= 1'b1;
        wait_cyc(6);
        rd(8'h00, got);
        chk(32'h000, got);
        chk(32'h0, {31'h0, lock_live_out});
        rd(8'h04, got);
        chk(32'h000, got);
        @(posedge clk_in);
        clock_fail_in <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        clk_in        = 1'b0;
        arst_n_in     = 1'b0;
        bus           = '0;
        ctrl          = '0;
        pll_lock_in   = 1'b0;
        clock_fail_in = 1'b0;
        strap         = 3'b111;
        err_count     = 0;
        total_checks  = 0;
        test_modes();
        do_reset(3'b111);
        test_lock_loss();
        test_exempt();
        test_clock_loss();
        test_external();
        complete_run();
    end
    initial
    begin
        #(50 * 5000);
        err_count++;
        complete_run();
    end
endmodule // pll_synth_status_flags_test
